// [rtl/hclk_divider.sv]
// Internal sensor clock enable generator from the master clock
`timescale 1ns/10ps
module hclk_divider
    import sensor_cfg_pkg::*;
#(
    parameter int W = 8
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Divide control
    input  wire logic [W-1:0] divide,
    // Sensor clock enable
    output logic              hclk_tick
);

    div_state_t st_reg;
    div_state_t st_next;

    // Zero and one both give a tick every master clock
    always_comb
    begin
        st_next = st_reg;
        if (divide == '0 || st_reg.cnt >= 8'(divide - 1'b1))
        begin
            st_next.cnt  = '0;
            st_next.tick = 1'b1;
        end
        else
        begin
            st_next.cnt  = st_reg.cnt + 8'h01;
            st_next.tick = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign hclk_tick = st_reg.tick;

endmodule : hclk_divider

// [rtl/image_sensor_config_regs.sv]
// Sensor config register bank behind a two-wire serial slave
`timescale 1ns/10ps
module image_sensor_config_regs
    import sensor_cfg_pkg::*;
#(
    parameter logic [7:0] REVISION   = 8'h5a,  // Arbitrary value
    parameter int         INIT_COUNT = INIT_CYCLES
)
(
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst,
    // Two-wire serial port
    input  wire logic  scl_in,
    input  wire logic  sda_in,
    output logic       sda_out,
    output logic       sda_oe,
    // Sensor pins
    input  wire logic  pdwn_pin,
    input  wire logic  snapshot_pin,
    input  wire logic  row_trig,
    input  wire logic  frame_trig,
    // Internal timing requests in master mode
    input  wire logic  int_row_due,
    input  wire logic  int_frame_due,
    // Controls to the sensor core
    output sensor_ctrl_t ctrl,
    output logic       hclk_tick
);

    typedef struct packed {
        link_state_t        link;
        link_state_t        after_ack;
        logic [3:0]         bit_cnt;
        logic [7:0]         shifter;
        logic [7:0]         ptr;
        logic               read_dir;
        logic               read_more;
        logic               sda_drive;
        logic               scl_prev;
        logic               sda_prev;
        logic [7:0]         main_a;
        logic [7:0]         main_b;
        logic [7:0]         pwr;
        logic [7:0]         divider;
        logic [7:0]         vmode;
        logic [INIT_W-1:0]  init_cnt;
        logic               snap_prev;
        logic               row_prev;
        logic               frame_prev;
        sensor_ctrl_t       ctrl;
    } cfg_state_t;

    cfg_state_t st_reg;
    cfg_state_t st_next;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;
    logic [7:0] rd_val;
    logic       busy_next;

    ////////////////////////////////////////////////////////////////////////
    // Read path

    // Reserved bits are never stored, so they read back as zero
    function automatic logic [7:0] read_reg(input cfg_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (s.ptr)
            OFF_REV:    v = REVISION;
            OFF_MAIN_A: v = s.main_a
                            | {s.ctrl.init_in_progress_flag, 7'h00};
            OFF_MAIN_B: v = s.main_b;
            OFF_PWR:    v = s.pwr;
            OFF_DIV:    v = s.divider;
            OFF_VMODE:  v = s.vmode;
            default:    v = 8'h00;
        endcase
        return v;
    endfunction : read_reg

    assign rd_val = read_reg(st_reg);

    ////////////////////////////////////////////////////////////////////////
    // Serial slave and control update

    // Line events from the previous sample; inputs arrive synchronous
    always_comb
    begin
        scl_rise   = scl_in & ~st_reg.scl_prev;
        scl_fall   = ~scl_in & st_reg.scl_prev;
        start_cond = scl_in & st_reg.scl_prev & st_reg.sda_prev & ~sda_in;
        stop_cond  = scl_in & st_reg.scl_prev & ~st_reg.sda_prev & sda_in;
        busy_next  = st_reg.init_cnt < INIT_W'(INIT_COUNT);
    end

    // Whole next state
    always_comb
    begin
        st_next          = st_reg;
        st_next.scl_prev = scl_in;
        st_next.sda_prev = sda_in;

        // Power-on initialization timer
        if (busy_next)
            st_next.init_cnt = st_reg.init_cnt + 1'b1;

        // Link protocol; start and stop override any byte in flight
        if (start_cond)
        begin
            st_next.link      = S_ADDR;
            st_next.bit_cnt   = '0;
            st_next.sda_drive = 1'b0;
        end
        else if (stop_cond)
        begin
            st_next.link      = S_IDLE;
            st_next.sda_drive = 1'b0;
        end
        else
        begin
            case (st_reg.link)
                S_IDLE:
                begin
                    st_next.sda_drive = 1'b0;
                end
                S_ADDR, S_PTR, S_WDATA:
                begin
                    if (scl_rise)
                    begin
                        st_next.shifter = {st_reg.shifter[6:0], sda_in};
                        st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
                    end
                    else if (scl_fall && st_reg.bit_cnt == BYTE_BITS)
                    begin
                        st_next.bit_cnt   = '0;
                        st_next.link      = S_ACK;
                        st_next.sda_drive = 1'b1;
                        case (st_reg.link)
                            S_ADDR:
                            begin
                                // Foreign address: stay off the bus
                                if (st_reg.shifter[7:1] != DEV_ADDR)
                                begin
                                    st_next.link      = S_IDLE;
                                    st_next.sda_drive = 1'b0;
                                end
                                st_next.read_dir  = st_reg.shifter[0];
                                st_next.after_ack = st_reg.shifter[0]
                                                    ? S_TX : S_PTR;
                            end
                            S_PTR:
                            begin
                                st_next.ptr       = st_reg.shifter;
                                st_next.after_ack = S_WDATA;
                            end
                            default:
                            begin
                                // Data byte write, pointer steps on
                                st_next.after_ack = S_WDATA;
                                st_next.ptr       = st_reg.ptr + 8'h01;
                                case (st_reg.ptr)
                                    OFF_MAIN_A: st_next.main_a =
                                        st_reg.shifter & MASK_MAIN_A;
                                    OFF_MAIN_B: st_next.main_b =
                                        st_reg.shifter & MASK_MAIN_B;
                                    OFF_PWR:    st_next.pwr =
                                        st_reg.shifter & MASK_PWR;
                                    OFF_DIV:    st_next.divider =
                                        st_reg.shifter & MASK_DIV;
                                    OFF_VMODE:  st_next.vmode =
                                        st_reg.shifter & MASK_VMODE;
                                    default:    st_next.ptr =
                                        st_reg.ptr + 8'h01;
                                endcase
                            end
                        endcase
                    end
                end
                S_ACK:
                begin
                    if (scl_fall)
                    begin
                        st_next.link      = st_reg.after_ack;
                        st_next.sda_drive = 1'b0;
                        if (st_reg.after_ack == S_TX)
                        begin
                            // First data bit goes out on this fall
                            st_next.shifter   = rd_val;
                            st_next.ptr       = st_reg.ptr + 8'h01;
                            st_next.sda_drive = ~rd_val[7];
                        end
                    end
                end
                S_TX:
                begin
                    if (scl_fall)
                    begin
                        if (st_reg.bit_cnt[2:0] == LAST_TX_BIT)
                        begin
                            st_next.link      = S_RACK;
                            st_next.sda_drive = 1'b0;
                            st_next.read_more = 1'b0;
                        end
                        else
                        begin
                            st_next.shifter   = {st_reg.shifter[6:0], 1'b0};
                            st_next.sda_drive = ~st_reg.shifter[6];
                        end
                        st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
                    end
                end
                S_RACK:
                begin
                    // Host acknowledge asks for the next byte
                    if (scl_rise)
                        st_next.read_more = ~sda_in;
                    else if (scl_fall)
                    begin
                        st_next.bit_cnt = '0;
                        if (st_reg.read_more)
                        begin
                            st_next.link      = S_TX;
                            st_next.shifter   = rd_val;
                            st_next.ptr       = st_reg.ptr + 8'h01;
                            st_next.sda_drive = ~rd_val[7];
                        end
                        else
                            st_next.link = S_IDLE;
                    end
                end
                default:
                begin
                    st_next.link      = S_IDLE;
                    st_next.sda_drive = 1'b0;
                end
            endcase
        end

        // Sensor controls, registered so every output is a flop
        st_next.ctrl.init_in_progress_flag = busy_next;
        st_next.ctrl.sensor_asleep =
            st_reg.main_a[BIT_SLEEP] | pdwn_pin;
        st_next.ctrl.defect_fix_enable = st_reg.main_a[BIT_DEFECT];
        st_next.ctrl.dark_comp_active  = ~st_reg.main_a[BIT_DARK];
        st_next.ctrl.mono_sensor_select = st_reg.main_b[BIT_MONO];
        st_next.ctrl.interlace_select  = st_reg.main_b[BIT_ILACE];
        st_next.ctrl.horiz_decimate_enable =
            st_reg.main_b[BIT_HDEC];
        st_next.ctrl.vert_decimate_enable =
            st_reg.main_b[BIT_VDEC];
        st_next.ctrl.external_sync_select =
            st_reg.main_b[BIT_SLAVE];
        st_next.ctrl.amp_skip_select   = st_reg.pwr[BIT_SKIP];
        st_next.ctrl.amp_sleep_bit     = st_reg.pwr[BIT_AMPSL];
        st_next.ctrl.converter_sleep_bit = st_reg.pwr[BIT_ADCSL];

        // Snapshot pin edge, ignored unless enabled
        st_next.snap_prev = snapshot_pin;
        st_next.ctrl.shutter_request = st_reg.main_a[BIT_SNAP]
            & snapshot_pin & ~st_reg.snap_prev;

        // Frame and row starts; slave mode waits for trigger edges
        st_next.row_prev   = row_trig;
        st_next.frame_prev = frame_trig;
        if (st_reg.main_b[BIT_SLAVE])
        begin
            st_next.ctrl.row_start   = row_trig & ~st_reg.row_prev;
            st_next.ctrl.frame_start =
                frame_trig & ~st_reg.frame_prev;
        end
        else
        begin
            st_next.ctrl.row_start   = int_row_due;
            st_next.ctrl.frame_start = int_frame_due;
        end
        // A sleeping or initializing sensor starts no rows or frames
        if (busy_next | st_next.ctrl.sensor_asleep)
        begin
            st_next.ctrl.row_start   = 1'b0;
            st_next.ctrl.frame_start = 1'b0;
        end
    end

    // State register; controls wake at their documented defaults
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg                            <= '0;
            st_reg.link                       <= S_IDLE;
            st_reg.after_ack                  <= S_IDLE;
            st_reg.scl_prev                   <= 1'b1;
            st_reg.sda_prev                   <= 1'b1;
            st_reg.divider                    <= RST_DIV;
            st_reg.ctrl.init_in_progress_flag <= 1'b1;
            st_reg.ctrl.dark_comp_active      <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sensor clock and outputs

    // Divider output is itself a flop inside the divider
    hclk_divider #(
        .W         (8)
    ) u_hclk (
        .clk       (clk),
        .rst       (rst),
        .divide    (st_reg.divider),
        .hclk_tick (hclk_tick)
    );

    // Open drain: the line is only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe  = st_reg.sda_drive;
    assign ctrl    = st_reg.ctrl;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Byte loaded for transmit from the revision offset is the fixed value
    AST_REV_FIXED: assert property (
        $rose(st_reg.link == S_TX) && $past(st_reg.ptr) == OFF_REV
        |-> st_reg.shifter == REVISION)
        else $error("revision read not fixed");

    AST_BUSY_END: assert property (
        $fell(ctrl.init_in_progress_flag)
        |-> st_reg.init_cnt == INIT_W'(INIT_COUNT))
        else $error("busy cleared at wrong time");

    AST_SLEEP_PIN: assert property (
        pdwn_pin |=> ctrl.sensor_asleep)
        else $error("power-down pin ignored");

    AST_SLEEP_BIT: assert property (
        st_reg.main_a[BIT_SLEEP] |=> ctrl.sensor_asleep)
        else $error("sleep bit ignored");

    AST_DARK_SENSE: assert property (
        $past(st_reg.main_a[BIT_DARK]) |-> !ctrl.dark_comp_active)
        else $error("dark level sense wrong");

    AST_SNAP_GATE: assert property (
        ctrl.shutter_request |-> $past(st_reg.main_a[BIT_SNAP])
        && $past(snapshot_pin))
        else $error("snapshot without enable");

    AST_SLAVE_ROW: assert property (
        st_reg.main_b[BIT_SLAVE] && !row_trig |=> !ctrl.row_start)
        else $error("slave row start without trigger");

    AST_MASTER_ROW: assert property (
        !st_reg.main_b[BIT_SLAVE] && !int_row_due |=> !ctrl.row_start)
        else $error("master row start without request");

    AST_RESERVED: assert property (
        (st_reg.main_a & ~MASK_MAIN_A) == 8'h00
        && (st_reg.main_b & ~MASK_MAIN_B) == 8'h00
        && (st_reg.pwr & ~MASK_PWR) == 8'h00)
        else $error("reserved bit stored");

    AST_ANALOG: assert property (
        {ctrl.amp_skip_select, ctrl.amp_sleep_bit, ctrl.converter_sleep_bit}
        == $past({st_reg.pwr[BIT_SKIP], st_reg.pwr[BIT_AMPSL],
                  st_reg.pwr[BIT_ADCSL]}))
        else $error("analog controls mismatch");

    AST_MONO: assert property (
        ctrl.mono_sensor_select == $past(st_reg.main_b[BIT_MONO]))
        else $error("sensor type mismatch");

    COV_WRITE: cover property (
        st_reg.link == S_WDATA ##1 st_reg.link == S_ACK);
    COV_READ: cover property (
        st_reg.link == S_TX ##[1:40] st_reg.link == S_RACK);
    COV_SLAVE: cover property (
        st_reg.main_b[BIT_SLAVE] ##1 ctrl.row_start);

endmodule : image_sensor_config_regs

// [rtl/sensor_cfg_pkg.sv]
// Package: register map, field layout and types of the sensor config bank
// Operation
// - Revision register reads a fixed value; host writes to it change nothing.
// - Busy bit reads 1 during power-on initialization, then 0.
// - Sleep bit set powers sensor down, same as the power-down pin.
// - Defect fix bit enables bad pixel detection and correction.
// - Dark level bit set disables compensation; cleared keeps it active.
// - Shutter pin enable bit lets the external snapshot pin act.
// - Mono select gives 2:1 row steps; colour gives 4:2 row pairs.
// - Interlace select picks interlaced readout, cleared means progressive.
// - Horizontal decimation enable bit switches horizontal sub-sampling.
// - Vertical decimation enable bit switches vertical sub-sampling.
// - External sync select makes sync signals slave inputs.
// - Amp skip routes sampler output straight to the converter.
// - Amp sleep bit powers down the gain amplifier.
// - Converter sleep bit powers down the 12-bit converter.
// - Divider values zero and one pass master clock; others divide it.
// - In slave mode frames and rows start only on external triggers.
package sensor_cfg_pkg;

    // Register offsets
    localparam logic [7:0] OFF_REV     = 8'h01;
    localparam logic [7:0] OFF_MAIN_A  = 8'h02;
    localparam logic [7:0] OFF_MAIN_B  = 8'h03;
    localparam logic [7:0] OFF_PWR     = 8'h04;
    localparam logic [7:0] OFF_DIV     = 8'h05;
    localparam logic [7:0] OFF_VMODE   = 8'h06;

    // Writable bits per register; everything else is reserved, except the read-only busy bit 7 of main A
    localparam logic [7:0] MASK_MAIN_A = 8'h78;
    localparam logic [7:0] MASK_MAIN_B = 8'hf4;
    localparam logic [7:0] MASK_PWR    = 8'h89;
    localparam logic [7:0] MASK_DIV    = 8'hff;
    localparam logic [7:0] MASK_VMODE  = 8'hf0;

    // Reset values
    localparam logic [7:0] RST_DIV     = 8'h04;

    // Field positions
    localparam int BIT_BUSY   = 7;
    localparam int BIT_SLEEP  = 6;
    localparam int BIT_DEFECT = 5;
    localparam int BIT_DARK   = 4;
    localparam int BIT_SNAP   = 3;
    localparam int BIT_MONO   = 7;
    localparam int BIT_ILACE  = 6;
    localparam int BIT_HDEC   = 5;
    localparam int BIT_VDEC   = 4;
    localparam int BIT_SLAVE  = 2;
    localparam int BIT_SKIP   = 7;
    localparam int BIT_AMPSL  = 3;
    localparam int BIT_ADCSL  = 0;

    // Serial link and power-on initialization constants
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [2:0] LAST_TX_BIT = 3'h7;
    localparam logic [6:0] DEV_ADDR    = 7'h3c;
    localparam int         INIT_W      = 16;
    localparam int         INIT_CYCLES = 64;

    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_PTR, S_WDATA, S_ACK, S_TX, S_RACK
    } link_state_t;

    typedef struct packed {
        logic sensor_asleep;
        logic defect_fix_enable;
        logic dark_comp_active;
        logic shutter_request;
        logic mono_sensor_select;
        logic interlace_select;
        logic horiz_decimate_enable;
        logic vert_decimate_enable;
        logic external_sync_select;
        logic amp_skip_select;
        logic amp_sleep_bit;
        logic converter_sleep_bit;
        logic init_in_progress_flag;
        logic frame_start;
        logic row_start;
    } sensor_ctrl_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } div_state_t;

endpackage : sensor_cfg_pkg

// [test/sensor_host_model.sv]
// Two-wire host model driving the sensor's serial port
`timescale 1ns/10ps
module sensor_host_model
(
    // Clock
    input  wire logic clk,
    // Serial lines
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    ////////////////////////////////////////////////////////////////////////
    // Both lines released at start
    initial
    begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // Waits n clocks, then steps just past the edge
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : hold

    // Six clocks per phase, above the four the port needs
    task automatic put_bit(input logic b);
        sda_low = ~b;
        hold(6);
        scl = 1'b1;
        hold(6);
        scl = 1'b0;
        hold(2);
    endtask : put_bit

    // Released data reads high through the pull-up
    task automatic get_bit(output logic b);
        sda_low = 1'b0;
        hold(6);
        scl = 1'b1;
        hold(3);
        b = sda;
        hold(3);
        scl = 1'b0;
        hold(2);
    endtask : get_bit

    // Also serves as repeated start
    task automatic start();
        sda_low = 1'b0;
        hold(3);
        scl = 1'b1;
        hold(6);
        sda_low = 1'b1;
        hold(6);
        scl = 1'b0;
        hold(2);
    endtask : start

    task automatic stop();
        sda_low = 1'b1;
        hold(3);
        scl = 1'b1;
        hold(6);
        sda_low = 1'b0;
        hold(6);
    endtask : stop

    // MSB first; returns 1 if acknowledged
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(a);
        ack = ~a;
    endtask : send_byte

    // Last byte gets a not-acknowledge
    task automatic recv_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(last);
    endtask : recv_byte
endmodule : sensor_host_model

// [test/test_image_sensor_config_regs.sv]
// Self-checking bench for the sensor config register bank
`timescale 1ns/10ps
module test_image_sensor_config_regs;
    import sensor_cfg_pkg::*;
    localparam logic [7:0] REV_VAL = 8'h5a; // Arbitrary value
    logic clk, rst, scl, sda, host_low, sda_out, sda_oe, hclk_tick;
    logic pdwn_pin, snapshot_pin, row_trig, frame_trig;
    logic int_row_due, int_frame_due, ack;
    logic [7:0] rd;
    sensor_ctrl_t ctrl;
    int n_errors, num_checks, n_cyc, n_tick, n_snap, n_row, n_frame;
    logic [7:0] offs [5] = '{OFF_MAIN_A, OFF_MAIN_B, OFF_PWR, OFF_DIV,
                             OFF_VMODE};
    logic [7:0] msks [5] = '{MASK_MAIN_A, MASK_MAIN_B, MASK_PWR, MASK_DIV,
                             MASK_VMODE};
    logic [7:0] rsts [5] = '{8'h00, 8'h00, 8'h00, RST_DIV, 8'h00};

    ////////////////////////////////////////////////////////////////////////
    // Open-drain wire with pull-up
    assign sda = ~(host_low | (sda_oe & ~sda_out));

    image_sensor_config_regs #(
        .REVISION      (REV_VAL),
        .INIT_COUNT    (8)
    ) dut (
        .clk           (clk),
        .rst           (rst),
        .scl_in        (scl),
        .sda_in        (sda),
        .sda_out       (sda_out),
        .sda_oe        (sda_oe),
        .pdwn_pin      (pdwn_pin),
        .snapshot_pin  (snapshot_pin),
        .row_trig      (row_trig),
        .frame_trig    (frame_trig),
        .int_row_due   (int_row_due),
        .int_frame_due (int_frame_due),
        .ctrl          (ctrl),
        .hclk_tick     (hclk_tick)
    );

    sensor_host_model host (
        .clk           (clk),
        .sda           (sda),
        .scl           (scl),
        .sda_low       (host_low)
    );

    always #20 clk = ~clk;

    // Pulses counted on the falling edge, where outputs are settled
    always @(negedge clk)
    begin
        n_cyc++;
        if (hclk_tick === 1'b1) n_tick++;
        if (ctrl.shutter_request === 1'b1) n_snap++;
        if (ctrl.row_start === 1'b1) n_row++;
        if (ctrl.frame_start === 1'b1) n_frame++;
        if (n_cyc == 60000)
        begin
            n_errors++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        host.start();
        host.send_byte({DEV_ADDR, 1'b0}, ack);
        host.send_byte(a, ack);
        host.send_byte(d, ack);
        check({15'h0000, ack}, 16'h0001, "data ack");
        host.stop();
    endtask : reg_write

    // Pointer set by a write, then repeated start to read
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        host.start();
        host.send_byte({DEV_ADDR, 1'b0}, ack);
        host.send_byte(a, ack);
        host.start();
        host.send_byte({DEV_ADDR, 1'b1}, ack);
        host.recv_byte(1'b1, rd);
        host.stop();
        check({8'h00, rd}, {8'h00, exp}, "read");
    endtask : reg_read

    // Ticks over 40 clocks after the divider settles
    task automatic ticks(input int exp);
        host.hold(10);
        n_tick = 0;
        host.hold(40);
        check(16'(n_tick), 16'(exp), "ticks");
    endtask : ticks

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk           = 1'b0;
        pdwn_pin      = 1'b0;
        snapshot_pin  = 1'b0;
        row_trig      = 1'b0;
        frame_trig    = 1'b0;
        int_row_due   = 1'b0;
        int_frame_due = 1'b0;
        rst = 1'b1;
        host.hold(12);
        check({ctrl.init_in_progress_flag, ctrl.dark_comp_active}, 16'h3,
              "reset ctrl");
        rst = 1'b0;
        host.hold(6);
        check(16'(ctrl.init_in_progress_flag), 16'h0001, "busy");
        host.hold(4);
        check(16'(ctrl.init_in_progress_flag), 16'h0000, "ready");
        reg_read(OFF_REV, REV_VAL);
        reg_write(OFF_REV, ~REV_VAL);
        reg_read(OFF_REV, REV_VAL);
        // Reset table; busy bit read as 0 before use
        for (int i = 0; i < 5; i++) reg_read(offs[i], rsts[i]);
        ticks(10);
        reg_read(8'h00, 8'h00);
        reg_read(8'h07, 8'h00);
        // Foreign device address must not be acknowledged
        host.start();
        host.send_byte({DEV_ADDR ^ 7'h01, 1'b0}, ack);
        host.stop();
        check({15'h0000, ack}, 16'h0000, "foreign ack");
        for (int i = 0; i < 5; i++) reg_write(offs[i], 8'hff);
        for (int i = 0; i < 5; i++) reg_read(offs[i], msks[i]);
        check({1'b0, ctrl}, 16'h67f8, "all set");
        check(16'({ctrl.horiz_decimate_enable, ctrl.vert_decimate_enable,
                   ctrl.external_sync_select}), 16'h0007, "main b");
        check(16'({ctrl.amp_skip_select, ctrl.amp_sleep_bit,
                   ctrl.converter_sleep_bit}), 16'h0007, "analog");
        for (int i = 0; i < 5; i++) reg_write(offs[i], 8'h00);
        check({1'b0, ctrl}, 16'h1000, "all clear");
        ticks(40);
        reg_write(OFF_DIV, 8'h05);
        ticks(8);
        pdwn_pin = 1'b1;
        host.hold(3);
        check(16'(ctrl.sensor_asleep), 16'h0001, "pin sleep");
        pdwn_pin = 1'b0;
        // Snapshot pulses with the pin enabled, then disabled
        for (int i = 0; i < 2; i++)
        begin
            reg_write(OFF_MAIN_A, i ? 8'h00 : 8'h08);
            snapshot_pin = 1'b1;
            host.hold(3);
            snapshot_pin = 1'b0;
            host.hold(3);
        end
        check(16'(n_snap), 16'h0001, "snapshots");
        // Slave: internal requests ignored, triggers start work
        reg_write(OFF_MAIN_B, 8'h04);
        n_row         = 0;
        n_frame       = 0;
        int_row_due   = 1'b1;
        int_frame_due = 1'b1;
        host.hold(10);
        int_row_due   = 1'b0;
        int_frame_due = 1'b0;
        check(16'(n_row + n_frame), 16'h0000, "slave idle");
        row_trig      = 1'b1;
        frame_trig    = 1'b1;
        host.hold(3);
        row_trig      = 1'b0;
        frame_trig    = 1'b0;
        host.hold(3);
        check(16'(n_row + n_frame), 16'h0002, "slave trig");
        reg_write(OFF_MAIN_B, 8'h00);
        int_row_due = 1'b1;
        host.hold(1);
        int_row_due = 1'b0;
        host.hold(3);
        check(16'(n_row), 16'h0002, "master row");
        test_done();
    end
endmodule : test_image_sensor_config_regs
